//--- verilog/rtcb_cfg.svh
// What this block does
// - Charger enables only when the enable key field bits 7..4 hold 1010.
// - Diode field 01 selects one diode, 10 selects two diodes.
// - Diode field 00 or 11 keeps the charger disabled whatever the key.
// - Resistor field 01, 10, 11 selects 2k, 4k, 8k; 00 selects none.
// - Resistor field 00 keeps the charger disabled whatever the key.
// - Clock burst moves the eight clock registers in order from address 0.
// - Clock burst write started with write lock set changes no clock register.
// - Charger configuration is never touched by a burst transfer.
// - Scratch RAM holds thirty-one bytes at consecutive addresses.
// - RAM burst moves the RAM words in order from address 0.
// - Clock burst write commits only after all eight bytes arrived.
// - RAM burst write stores each finished byte at once.
// - Write lock bit 7 of control blocks writes to every other register.
`ifndef RTCB_CFG_SVH
`define RTCB_CFG_SVH

// ----------------------------------------------------------------------
// charger configuration fields
// ----------------------------------------------------------------------
`define RTCB_KEY_HI 7
`define RTCB_KEY_LO 4
`define RTCB_DS_HI 3
`define RTCB_DS_LO 2
`define RTCB_RS_HI 1
`define RTCB_RS_LO 0
`define RTCB_KEY_ON 4'hA
`define RTCB_DS_ONE 2'h1
`define RTCB_DS_TWO 2'h2
`define RTCB_RS_NONE 2'h0
`define RTCB_RS_2K 2'h1
`define RTCB_RS_4K 2'h2
`define RTCB_RS_8K 2'h3

// ----------------------------------------------------------------------
// command byte and address map
// ----------------------------------------------------------------------
`define RTCB_CMD_RD 0
`define RTCB_CMD_A_LO 1
`define RTCB_CMD_A_HI 5
`define RTCB_CMD_RAM 6
`define RTCB_CMD_EN 7
`define RTCB_BURST_ADDR 5'h1F
`define RTCB_CLK_LAST 5'h07
`define RTCB_CTRL_IDX 5'h07
`define RTCB_CHG_IDX 5'h08
`define RTCB_RAM_WORDS 31
`define RTCB_RAM_LAST 5'h1E
`define RTCB_WP_BIT 7
`define RTCB_CTRL_MASK 8'h80
`define RTCB_LAST_BIT 3'h7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RTCB_CHG_RST 8'h00
`define RTCB_REG_RST 8'h00

`endif

//--- verilog/rtcb_pkg.sv
package rtcb_pkg;

	// transfer phase of the serial link
	typedef enum logic [1:0] {
		PH_CMD = 2'b00,
		PH_DATA = 2'b01,
		PH_DONE = 2'b10
	} rtcb_phase_t;

	// decoded charger controls
	typedef struct packed {
		logic enable;
		logic diode_one;
		logic diode_two;
		logic res_2k;
		logic res_4k;
		logic res_8k;
	} rtcb_chg_t;

	// link-side transfer state, cleared whenever the gate drops
	typedef struct packed {
		rtcb_phase_t phase;
		logic [2:0] bit_cnt;
		logic [4:0] byte_cnt;
		logic [7:0] cmd;
		logic [7:0] rx;
		logic [7:0] tx;
		logic [4:0] addr;
		logic burst;
		logic wp_start;
		logic io_out;
		logic io_oe;
		logic [7:0][7:0] stage;
	} rtcb_link_t;

	// register storage kept across transfers
	typedef struct packed {
		logic [7:0][7:0] clk;
		logic [7:0] chg;
	} rtcb_store_t;

	// system-side output state
	typedef struct packed {
		logic [6:0] prev;
		rtcb_chg_t chg;
		logic lock;
	} rtcb_sys_t;

endpackage : rtcb_pkg

//--- verilog/rtcb_sync.sv
`timescale 1ns/1ps
module rtcb_sync #(
	parameter int WIDTH = 7
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	// first stage is read only by the second stage
	logic [WIDTH-1:0] meta_r;

	// ------------------------------------------------------------------
	// two-flop level synchroniser
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : rtcb_sync

//--- verilog/rtcb_ram.sv
`timescale 1ns/1ps
module rtcb_ram #(
	parameter int DEPTH = 31,
	parameter int AW = 5,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata_r
);
	logic [DW-1:0] mem [DEPTH];

	// ------------------------------------------------------------------
	// scratch store, registered read
	// ------------------------------------------------------------------
	// addresses past the last word read zero and never write
	always_ff @(posedge clk) begin
		if (we && (waddr < DEPTH)) begin
			mem[waddr] <= wdata;
		end
		rdata_r <= (raddr < DEPTH) ? mem[raddr] : '0;
	end
endmodule : rtcb_ram

//--- verilog/rtcb_top.sv
`timescale 1ns/1ps
`include "rtcb_cfg.svh"
module rtcb_top
	import rtcb_pkg::*;
#(
	parameter int RAM_WORDS = `RTCB_RAM_WORDS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic ce,
	input wire logic io_in,
	output logic io_out,
	output logic io_oe,
	output rtcb_chg_t charger,
	output logic wr_lock
);
	rtcb_link_t lt_r, lt_nxt;
	rtcb_store_t st_r, st_nxt;
	rtcb_sys_t sy_r, sy_nxt;
	rtcb_chg_t chg_dec;
	logic [7:0] cmd_full, byte_in, rd_byte, clk_rd, ram_rdata;
	logic [4:0] cmd_addr, first_addr, next_addr, rd_addr;
	logic [7:0] clk_we;
	logic [7:0][7:0] clk_wdata;
	logic [6:0] sync_q;
	logic wp, cmd_burst, wr_go, space_ram, ram_we, chg_we, last_wr;

	// next byte address: single access repeats, burst wraps at the end
	function automatic logic [4:0] step_addr(input logic [4:0] a,
			input logic is_ram, input logic burst);
		logic [4:0] last;
		last = is_ram ? `RTCB_RAM_LAST : `RTCB_CLK_LAST;
		if (!burst) begin
			step_addr = a;
		end else if (a == last) begin
			step_addr = 5'h00;
		end else begin
			step_addr = a + 5'h01;
		end
	endfunction : step_addr

	// ------------------------------------------------------------------
	// charger decode
	// ------------------------------------------------------------------
	always_comb begin
		chg_dec.diode_one = st_r.chg[`RTCB_DS_HI:`RTCB_DS_LO]
			== `RTCB_DS_ONE;
		chg_dec.diode_two = st_r.chg[`RTCB_DS_HI:`RTCB_DS_LO]
			== `RTCB_DS_TWO;
		chg_dec.res_2k = st_r.chg[`RTCB_RS_HI:`RTCB_RS_LO]
			== `RTCB_RS_2K;
		chg_dec.res_4k = st_r.chg[`RTCB_RS_HI:`RTCB_RS_LO]
			== `RTCB_RS_4K;
		chg_dec.res_8k = st_r.chg[`RTCB_RS_HI:`RTCB_RS_LO]
			== `RTCB_RS_8K;
		// key, a legal diode code and a real resistor are all required
		chg_dec.enable =
			(st_r.chg[`RTCB_KEY_HI:`RTCB_KEY_LO] == `RTCB_KEY_ON)
			&& (chg_dec.diode_one || chg_dec.diode_two)
			&& (st_r.chg[`RTCB_RS_HI:`RTCB_RS_LO]
			!= `RTCB_RS_NONE);
	end

	// ------------------------------------------------------------------
	// read path and write decisions
	// ------------------------------------------------------------------
	always_comb begin
		wp = st_r.clk[`RTCB_CTRL_IDX][`RTCB_WP_BIT];
		cmd_full = {io_in, lt_r.cmd[6:0]};
		byte_in = {io_in, lt_r.rx[6:0]};
		cmd_addr = lt_r.cmd[`RTCB_CMD_A_HI:`RTCB_CMD_A_LO];
		cmd_burst = (cmd_addr == `RTCB_BURST_ADDR);
		first_addr = cmd_burst ? 5'h00 : cmd_addr;
		space_ram = lt_r.cmd[`RTCB_CMD_RAM];
		next_addr = step_addr(lt_r.addr, space_ram, lt_r.burst);
		// the RAM read register must already hold the byte to be loaded
		rd_addr = (lt_r.phase == PH_CMD) ? first_addr : next_addr;
		if (rd_addr <= `RTCB_CLK_LAST) begin
			clk_rd = st_r.clk[rd_addr[2:0]];
		end else if (rd_addr == `RTCB_CHG_IDX) begin
			clk_rd = st_r.chg;
		end else begin
			clk_rd = `RTCB_REG_RST;
		end
		rd_byte = space_ram ? ram_rdata : clk_rd;
		wr_go = (lt_r.phase == PH_DATA) && !lt_r.cmd[`RTCB_CMD_RD]
			&& (lt_r.bit_cnt == `RTCB_LAST_BIT)
			&& lt_r.cmd[`RTCB_CMD_EN];
		// ram bytes go in as each one completes
		ram_we = wr_go && space_ram && !wp;
		chg_we = wr_go && !space_ram && !lt_r.burst && !wp
			&& (lt_r.addr == `RTCB_CHG_IDX);
		clk_wdata = lt_r.stage;
		clk_wdata[lt_r.addr[2:0]] = byte_in;
		clk_we = 8'h00;
		if (wr_go && !space_ram) begin
			if (lt_r.burst) begin
				// all eight land together, or none if locked at start
				if ((lt_r.byte_cnt == `RTCB_CLK_LAST) && !lt_r.wp_start) begin
					clk_we = 8'hFF;
				end
			end else if ((lt_r.addr == `RTCB_CTRL_IDX) ||
					((lt_r.addr <= `RTCB_CLK_LAST) && !wp)) begin
				clk_we[lt_r.addr[2:0]] = 1'b1;
			end
		end
		last_wr = !lt_r.burst
			|| (!space_ram && (lt_r.byte_cnt == `RTCB_CLK_LAST))
			|| (space_ram && (lt_r.byte_cnt == `RTCB_RAM_LAST));
	end

	// ------------------------------------------------------------------
	// link sequencer
	// ------------------------------------------------------------------
	always_comb begin
		lt_nxt = lt_r;
		case (lt_r.phase)
			PH_CMD: begin
				lt_nxt.cmd[lt_r.bit_cnt] = io_in;
				lt_nxt.bit_cnt = lt_r.bit_cnt + 3'h1;
				if (lt_r.bit_cnt == `RTCB_LAST_BIT) begin
					lt_nxt.phase = PH_DATA;
					lt_nxt.burst = cmd_burst;
					lt_nxt.addr = first_addr;
					lt_nxt.byte_cnt = 5'h00;
					lt_nxt.wp_start = wp;
					if (cmd_full[`RTCB_CMD_RD]) begin
						// first bit goes out right after the command
						lt_nxt.tx = rd_byte;
						lt_nxt.io_out = rd_byte[0];
						lt_nxt.io_oe = 1'b1;
					end
				end
			end
			PH_DATA: begin
				lt_nxt.bit_cnt = lt_r.bit_cnt + 3'h1;
				lt_nxt.rx[lt_r.bit_cnt] = io_in;
				if (lt_r.cmd[`RTCB_CMD_RD]) begin
					// reads keep going for as long as the gate is high; bursts wrap, single reads repeat
					if (lt_r.bit_cnt == `RTCB_LAST_BIT) begin
						lt_nxt.addr = next_addr;
						lt_nxt.tx = rd_byte;
						lt_nxt.io_out = rd_byte[0];
					end else begin
						lt_nxt.tx = {1'b0, lt_r.tx[7:1]};
						lt_nxt.io_out = lt_r.tx[1];
					end
				end else if (lt_r.bit_cnt == `RTCB_LAST_BIT) begin
					lt_nxt.stage[lt_r.byte_cnt[2:0]] = byte_in;
					lt_nxt.byte_cnt = lt_r.byte_cnt + 5'h01;
					lt_nxt.addr = next_addr;
					if (last_wr) begin
						lt_nxt.phase = PH_DONE;
					end
				end
			end
			PH_DONE: begin
				// extra clocks after a write are ignored
				lt_nxt.phase = PH_DONE;
			end
			default: begin
				lt_nxt.phase = PH_DONE;
			end
		endcase
	end

	// transfer state dies with the gate, so a torn frame leaves nothing but the RAM burst bytes already finished
	always_ff @(posedge sclk or negedge ce) begin
		if (!ce) begin
			lt_r <= '0;
		end else begin
			lt_r <= lt_nxt;
		end
	end

	// ------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		for (int i = 0; i < 8; i++) begin
			if (clk_we[i]) begin
				st_nxt.clk[i] = (i == 7) ? (clk_wdata[i] & `RTCB_CTRL_MASK)
					: clk_wdata[i];
			end
		end
		if (chg_we) begin
			st_nxt.chg = byte_in;
		end
	end

	// the link clock is idle while rst is applied, so async clear is safe
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			st_r.clk <= '0;
			st_r.chg <= `RTCB_CHG_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	rtcb_ram #(
		.DEPTH(RAM_WORDS),
		.AW(5),
		.DW(8)
	) u_ram (
		.clk(sclk),
		.we(ram_we),
		.waddr(lt_r.addr),
		.wdata(byte_in),
		.raddr(rd_addr),
		.rdata_r(ram_rdata)
	);

	// ------------------------------------------------------------------
	// crossing to the system clock
	// ------------------------------------------------------------------
	rtcb_sync #(
		.WIDTH(7)
	) u_sync (
		.clk(sys_clk),
		.rst(rst),
		.d({chg_dec, wp}),
		.q(sync_q)
	);

	// bits can arrive skewed; take a value only once it held two cycles
	always_comb begin
		sy_nxt = sy_r;
		sy_nxt.prev = sync_q;
		if (sync_q == sy_r.prev) begin
			sy_nxt.chg = rtcb_chg_t'(sync_q[6:1]);
			sy_nxt.lock = sync_q[0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sy_r <= '0;
		end else begin
			sy_r <= sy_nxt;
		end
	end

	assign io_out = lt_r.io_out;
	assign io_oe = lt_r.io_oe;
	assign charger = sy_r.chg;
	assign wr_lock = sy_r.lock;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence s_burst_cmd;
		(lt_r.phase == PH_CMD) && (lt_r.bit_cnt == 3'h7)
			&& (cmd_addr == 5'h1F);
	endsequence

	sequence s_last_clk_byte;
		(lt_r.phase == PH_DATA) && lt_r.burst && !space_ram
			&& !lt_r.cmd[0] && lt_r.cmd[7] && (lt_r.byte_cnt == 5'h07)
			&& (lt_r.bit_cnt == 3'h7) && !lt_r.wp_start;
	endsequence

	a_key_gate: assert property (@(posedge sclk) disable iff (rst)
		chg_dec.enable |-> (st_r.chg[7:4] == 4'hA))
		else $error("charger enabled without key");
	a_diode_map: assert property (@(posedge sclk) disable iff (rst)
		(st_r.chg[3:2] == 2'h2) |-> (chg_dec.diode_two && !chg_dec.diode_one))
		else $error("diode code 10 not decoded to two diodes");
	a_diode_gate: assert property (@(posedge sclk) disable iff (rst)
		(st_r.chg[3:2] == 2'h0 || st_r.chg[3:2] == 2'h3) |-> !chg_dec.enable)
		else $error("charger enabled with bad diode code");
	a_res_map: assert property (@(posedge sclk) disable iff (rst)
		(st_r.chg[1:0] == 2'h3) |->
		(chg_dec.res_8k && !chg_dec.res_2k && !chg_dec.res_4k))
		else $error("resistor code 11 not decoded to 8k");
	a_res_gate: assert property (@(posedge sclk) disable iff (rst)
		(st_r.chg[1:0] == 2'h0) |-> !chg_dec.enable)
		else $error("charger enabled with no resistor");
	a_burst_start: assert property (@(posedge sclk)
		disable iff (rst || !ce)
		s_burst_cmd |=> (lt_r.addr == 5'h00) && lt_r.burst)
		else $error("burst did not start at address 0");
	a_lock_burst: assert property (@(posedge sclk)
		disable iff (rst || !ce)
		(lt_r.burst && lt_r.wp_start && !space_ram) |=> $stable(st_r.clk))
		else $error("locked clock burst changed a register");
	a_chg_noburst: assert property (@(posedge sclk)
		disable iff (rst || !ce)
		(lt_r.phase == PH_DATA && lt_r.burst) |=> $stable(st_r.chg))
		else $error("burst touched charger configuration");
	// the commit edge is the frame's last, so a gate-low disable would
	// kill every attempt; the stored bytes still stand at the next edge
	a_clk_commit: assert property (@(posedge sclk)
		disable iff (rst)
		s_last_clk_byte |=> (st_r.clk[0] == $past(lt_r.stage[0]))
		&& (st_r.clk[6] == $past(lt_r.stage[6])))
		else $error("clock burst did not commit staged bytes");
	a_ram_commit: assert property (@(posedge sclk)
		disable iff (rst || !ce)
		ram_we |-> (lt_r.bit_cnt == 3'h7) && (lt_r.phase == PH_DATA)
		&& !st_r.clk[7][7])
		else $error("ram write outside a finished byte");
	a_wp_block: assert property (@(posedge sclk) disable iff (rst)
		st_r.clk[7][7] |=> ($stable(st_r.chg) && $stable(st_r.clk[0])))
		else $error("write lock did not block a write");
endmodule : rtcb_top

//--- verification/rtcb_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// host side of the three-wire link
// ----------------------------------------------------------------------
module rtcb_host (
	output logic sclk,
	output logic ce,
	output logic drv,
	output logic dat,
	input wire logic io_wire
);
	localparam int HALF = 80;

	// serial clock stands low outside frames, line released
	initial begin
		sclk = 1'b0;
		ce = 1'b0;
		drv = 1'b0;
		dat = 1'b0;
	end

	// gate rises while the serial clock is low
	task automatic open_frame();
		ce = 1'b1;
		#(HALF * 2);
	endtask : open_frame

	// data set in the low half, held across the rising edge, lsb first
	task automatic put_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			drv = 1'b1;
			dat = b[i];
			#HALF;
			sclk = 1'b1;
			#HALF;
			sclk = 1'b0;
		end
	endtask : put_byte

	// bit sampled just before the edge that moves the device on
	task automatic get_byte(output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			drv = 1'b0;
			#HALF;
			b[i] = io_wire;
			sclk = 1'b1;
			#HALF;
			sclk = 1'b0;
		end
	endtask : get_byte

	// a low gate ends the access; leave an idle gap afterwards
	task automatic close_frame();
		drv = 1'b0;
		#HALF;
		ce = 1'b0;
		#(HALF * 4);
	endtask : close_frame
endmodule : rtcb_host

//--- verification/rtcb_burst_and_charger_ctrl_tb_top.sv
`timescale 1ns/1ps
module rtcb_burst_and_charger_ctrl_tb_top;
	import rtcb_pkg::*;
	logic sys_clk;
	logic rst;
	wire sclk, ce, drv, dat;
	logic io_out, io_oe, wr_lock;
	rtcb_chg_t charger;
	int fails = 0;
	int comparisons = 0;
	logic [7:0] clk_m [8];
	logic [7:0] ram_m [31];
	logic [7:0] b;
	// burst commands: all five address bits set
	localparam logic [7:0] clk_bwr = 8'hBE;
	localparam logic [7:0] clk_brd = 8'hBF;
	localparam logic [7:0] ram_bwr = 8'hFE;
	localparam logic [7:0] ram_brd = 8'hFF;
	// pull-down on the data line; host wins to keep the wire known
	wire io_wire = drv ? dat : (io_oe ? io_out : 1'b0);

	rtcb_top i_dut (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .ce(ce),
		.io_in(io_wire), .io_out(io_out), .io_oe(io_oe),
		.charger(charger), .wr_lock(wr_lock));
	rtcb_host i_host (.sclk(sclk), .ce(ce), .drv(drv), .dat(dat),
		.io_wire(io_wire));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------------
	// reporting
	// ------------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp,
		input string what);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t ns: %s seen %h expected %h", $time, what,
				seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------------
	// link helpers
	// ------------------------------------------------------------------
	task automatic wr1(input logic [7:0] cmd, input logic [7:0] d);
		i_host.open_frame();
		i_host.put_byte(cmd);
		i_host.put_byte(d);
		i_host.close_frame();
	endtask : wr1

	task automatic rd1(input logic [7:0] cmd, output logic [7:0] d);
		i_host.open_frame();
		i_host.put_byte(cmd);
		i_host.get_byte(d);
		i_host.close_frame();
	endtask : rd1

	// nine bytes so the wrap back to address 0 is seen too
	task automatic rd_clk_all();
		logic [7:0] r;
		i_host.open_frame();
		i_host.put_byte(clk_brd);
		for (int i = 0; i < 9; i++) begin
			i_host.get_byte(r);
			check(r, clk_m[i % 8], "clock burst read");
		end
		i_host.close_frame();
	endtask : rd_clk_all

	// bounded wait for a settled level on the system side
	task automatic wait_lvl(input logic [7:0] exp, input int sel);
		bit hit;
		hit = 1'b0;
		for (int i = 0; i < 20 && !hit; i++) begin
			@(posedge sys_clk);
			if (sel == 0 && {7'h0, charger.enable} === exp) hit = 1'b1;
			if (sel == 1 && {7'h0, wr_lock} === exp) hit = 1'b1;
		end
		// a level that never settles ends the run as a failure
		if (!hit) begin
			fails++;
			$display("Error at %0t ns: level wait ran out", $time);
			finish_test();
		end
		#1;
	endtask : wait_lvl

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_charger();
		logic [7:0] v [7] = '{8'hA5, 8'hA6, 8'hAB, 8'hA4, 8'hA1, 8'hAD,
			8'h55};
		rtcb_chg_t e;
		rd1(8'h91, b);
		check(b, 8'h00, "config after reset");
		for (int k = 0; k < 7; k++) begin
			e.diode_one = v[k][3:2] == 2'h1;
			e.diode_two = v[k][3:2] == 2'h2;
			e.res_2k = v[k][1:0] == 2'h1;
			e.res_4k = v[k][1:0] == 2'h2;
			e.res_8k = v[k][1:0] == 2'h3;
			e.enable = v[k][7:4] == 4'hA && (e.diode_one || e.diode_two) &&
				v[k][1:0] != 2'h0;
			wr1(8'h90, v[k]);
			wait_lvl({7'h0, e.enable}, 0);
			check({7'h0, charger.enable}, {7'h0, e.enable}, "enable");
			check({2'h0, charger}, {2'h0, e}, "choice");
			rd1(8'h91, b);
			check(b, v[k], "config read");
		end
	endtask : t_charger

	task automatic t_clk_burst();
		i_host.open_frame();
		i_host.put_byte(clk_bwr);
		for (int i = 0; i < 8; i++) begin
			clk_m[i] = (i == 7) ? 8'h00 : 8'h13 + 8'(i * 17);
			i_host.put_byte((i == 7) ? 8'h7F : clk_m[i]);
		end
		i_host.close_frame();
		rd_clk_all();
		rd1(8'h85, b);
		check(b, clk_m[2], "single clock read");
		rd1(8'h91, b);
		check(b, 8'h55, "config kept by burst");
		// cut short after three bytes: nothing may land
		i_host.open_frame();
		i_host.put_byte(clk_bwr);
		for (int i = 0; i < 3; i++) i_host.put_byte(~clk_m[i]);
		i_host.close_frame();
		rd_clk_all();
		check({7'h0, io_oe}, 8'h00, "line released after gate low");
	endtask : t_clk_burst

	task automatic t_ram();
		i_host.open_frame();
		i_host.put_byte(ram_bwr);
		for (int i = 0; i < 31; i++) begin
			ram_m[i] = 8'(i) ^ 8'h5A;
			i_host.put_byte(ram_m[i]);
		end
		i_host.close_frame();
		// partial burst: each finished byte must still be stored
		i_host.open_frame();
		i_host.put_byte(ram_bwr);
		for (int i = 0; i < 5; i++) begin
			ram_m[i] = 8'hC0 + 8'(i);
			i_host.put_byte(ram_m[i]);
		end
		ram_m[5] = 8'hFF;
		i_host.put_byte(ram_m[5]);
		i_host.close_frame();
		wr1(8'hFC, 8'h77);
		ram_m[30] = 8'h77;
		i_host.open_frame();
		i_host.put_byte(ram_brd);
		for (int i = 0; i < 32; i++) begin
			i_host.get_byte(b);
			check(b, ram_m[i % 31], "ram burst read");
		end
		i_host.close_frame();
	endtask : t_ram

	task automatic t_lock();
		wr1(8'h8E, 8'h80);
		clk_m[7] = 8'h80;
		wait_lvl(8'h01, 1);
		check({7'h0, wr_lock}, 8'h01, "lock flag");
		i_host.open_frame();
		i_host.put_byte(clk_bwr);
		for (int i = 0; i < 8; i++) i_host.put_byte(~clk_m[i]);
		i_host.close_frame();
		rd_clk_all();
		wr1(8'h80, 8'h44);
		wr1(8'hC0, 8'h44);
		wr1(8'h90, 8'hA5);
		rd1(8'h81, b);
		check(b, clk_m[0], "locked clock write");
		rd1(8'hC1, b);
		check(b, ram_m[0], "locked ram write");
		rd1(8'h91, b);
		check(b, 8'h55, "locked config write");
		wr1(8'h8E, 8'h00);
		clk_m[7] = 8'h00;
		wait_lvl(8'h00, 1);
		check({7'h0, wr_lock}, 8'h00, "unlock");
		rd_clk_all();
		// command with its enable bit low: the write must be ignored
		wr1(8'h10, 8'hA9);
		rd1(8'h91, b);
		check(b, 8'h55, "write without enable bit");
	endtask : t_lock

	// watchdog against a hung link or a stuck wait
	initial begin
		#600us;
		fails++;
		$display("Error at %0t ns: run did not complete", $time);
		finish_test();
	end

	initial begin
		rst = 1'b1;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		// look off the edge; also skews the link clock from sys_clk
		#3;
		check({2'h0, charger}, 8'h00, "charger after reset");
		check({7'h0, wr_lock}, 8'h00, "lock after reset");
		t_charger();
		t_clk_burst();
		t_ram();
		t_lock();
		finish_test();
	end
endmodule : rtcb_burst_and_charger_ctrl_tb_top
